// ==== include/spilcd_pkg.sv ====
// Shared constants and types for the serial character display port
package spilcd_pkg;

  // ----------------------------------------------------------------
  // Shifted byte layout
  // ----------------------------------------------------------------
  localparam int NIBBLE_W = 4;
  typedef struct packed {
    logic                strobe;   // Display enable strobe
    logic                rs;       // Register select: 0 command, 1 data
    logic                spare_two;
    logic                spare_one;
    logic [NIBBLE_W-1:0] nibble;   // To the upper display data lines
  } spilcd_byte_s;
  localparam int BYTE_W = $bits(spilcd_byte_s);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } spilcd_req_s;

  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LAST   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h0c;

  // Control fields
  localparam int CTRL_PORT_EN   = 0;
  localparam int CTRL_PACE_EN   = 1;
  localparam int CTRL_PHASE_CLR = 2;
  localparam logic CTRL_PORT_EN_RST = 1'b1;
  localparam logic CTRL_PACE_EN_RST = 1'b1;

  // Status fields
  localparam int STAT_SEQ_ERR  = 0;
  localparam int STAT_PACE_ERR = 1;
  localparam int STAT_PHASE    = 2;

  localparam int COUNT_W = 16;

  // ----------------------------------------------------------------
  // Nibble pairing and command codes
  // ----------------------------------------------------------------
  typedef enum logic {
    PHASE_UPPER = 1'b0,
    PHASE_LOWER = 1'b1
  } spilcd_phase_e;

  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam logic [7:0] CMD_HOME  = 8'h02;

  // ----------------------------------------------------------------
  // Pacing times
  // ----------------------------------------------------------------
  localparam int REF_PERIOD_NS = 8;
  localparam int WAIT_SHORT_NS = 40000;
  localparam int WAIT_LONG_NS  = 1650000;
  localparam int WAIT_SHORT_CYCLES =
    (WAIT_SHORT_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int WAIT_LONG_CYCLES =
    (WAIT_LONG_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

endpackage

// ==== rtl/spilcd_shift.sv ====
// Serial byte receiver running on the link clock
`timescale 1ns/10ps
module spilcd_shift
  import spilcd_pkg::*;
(
  // Link pins
  input  wire logic              spi_sclk,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  // Reset
  input  wire logic              reset_n,
  // Completed byte toward the core clock
  output logic [BYTE_W-1:0]      byte_hold,
  output logic                   byte_toggle
);

  logic [2:0]        bit_count;
  logic [BYTE_W-2:0] shift;
  wire               link_rst_n = reset_n & ~spi_cs_n;
  wire               last_bit   = (bit_count == 3'h7);

  // ----------------------------------------------------------------
  // Bit gathering, most significant bit first
  // ----------------------------------------------------------------
  // Deselect aborts a partial byte, since the clock may stop anywhere
  always_ff @(posedge spi_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_count <= 3'h0;
      shift     <= '0;
    end
    else
    begin
      bit_count <= bit_count + 3'h1;
      shift     <= {shift[BYTE_W-3:0], spi_mosi};
    end
  end

  // Held byte and toggle survive deselect, so no false event appears
  always_ff @(posedge spi_sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      byte_hold   <= '0;
      byte_toggle <= 1'b0;
    end
    else if (last_bit && !spi_cs_n)
    begin
      byte_hold   <= {shift, spi_mosi};
      byte_toggle <= ~byte_toggle;
    end
  end

endmodule // spilcd_shift

// ==== rtl/spilcd_top.sv ====
// Serial to parallel character display port with pacing monitor
// How it works
// R1: Low byte nibble drives the display's upper four data lines.
// R2: Bits four and five go only to spare outputs.
// R3: Bit six drives register select: 0 command, 1 character data.
// R4: Bit seven drives the enable strobe, high when set.
// R5: Host sends each write as three transfers: strobe low, high, low.
// R6: Display is write only; host paces by fixed waits, not polling.
// R7: Display runs in four bit mode, modules up to 80 characters.
// R8: Lower four display data lines are held low always.
// R9: Host waits 1.65 ms after clear and home commands.
// R10: Host waits 40 us after any other write.
// R11: Host sends full bytes as two nibbles, upper first, same select.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
module spilcd_top
  import spilcd_pkg::*;
#(
  parameter int unsigned WAIT_SHORT = WAIT_SHORT_CYCLES,
  parameter int unsigned WAIT_LONG  = WAIT_LONG_CYCLES
)
(
  // Core clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // Register port
  input  wire spilcd_pkg::spilcd_req_s reg_req,
  output logic [spilcd_pkg::DATA_W-1:0] reg_rdata,
  // Serial link
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_mosi,
  // Display pins
  output logic [spilcd_pkg::NIBBLE_W-1:0] display_upper_data_lines,
  output logic [spilcd_pkg::NIBBLE_W-1:0] display_lower_data_lines,
  output logic                       register_select_bit,
  output logic                       display_enable_strobe,
  output logic                       spare_output_one,
  output logic                       spare_output_two
);

  localparam int TIMER_W = $clog2(WAIT_LONG + 1);
  localparam logic [TIMER_W-1:0] T_SHORT = TIMER_W'(WAIT_SHORT);
  localparam logic [TIMER_W-1:0] T_LONG  = TIMER_W'(WAIT_LONG);

  // ----------------------------------------------------------------
  // Link side receiver
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] link_byte;
  logic              link_toggle;

  spilcd_shift u_shift
  (
    .spi_sclk    (spi_sclk),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .reset_n     (reset_n),
    .byte_hold   (link_byte),
    .byte_toggle (link_toggle)
  );

  // ----------------------------------------------------------------
  // Crossing into the core clock
  // ----------------------------------------------------------------
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;

  // Toggle passes two flops; the held byte is stable once it shows
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
    end
    else
    begin
      tog_meta <= link_toggle;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
    end
  end

  // ----------------------------------------------------------------
  // Control and decode
  // ----------------------------------------------------------------
  logic                port_en;
  logic                pace_en;
  spilcd_byte_s        cur;
  spilcd_byte_s        last_byte;
  spilcd_phase_e       phase;
  logic [NIBBLE_W-1:0] upper_held;
  logic                need_long;
  logic [TIMER_W-1:0]  timer;
  logic                seq_err;
  logic                pace_err;
  logic [COUNT_W-1:0]  write_count;

  wire byte_valid = tog_sync ^ tog_seen;
  wire spilcd_byte_s in_byte = spilcd_byte_s'(link_byte);
  wire take       = byte_valid & port_en;

  wire wr_ctrl   = reg_req.wr && (reg_req.addr == OFS_CTRL);
  wire wr_status = reg_req.wr && (reg_req.addr == OFS_STATUS);
  wire phase_clr = wr_ctrl && reg_req.wdata[CTRL_PHASE_CLR];

  // Strobe edges as seen on the display pin
  wire strobe_rise = take & in_byte.strobe & ~cur.strobe;
  wire strobe_fall = take & ~in_byte.strobe & cur.strobe;
  // Nibble or select moved while a write is in progress
  wire seq_bad = take & (cur.strobe | in_byte.strobe) &
                 ((in_byte.nibble != cur.nibble) | (in_byte.rs != cur.rs));
  wire [TIMER_W-1:0] need_wait = need_long ? T_LONG : T_SHORT;
  wire pace_bad = strobe_rise & pace_en & (timer < need_wait);
  wire [7:0] full_byte = {upper_held, cur.nibble};
  wire long_cmd = ~cur.rs &
                  ((full_byte == CMD_CLEAR) | (full_byte == CMD_HOME));

  // Control register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port_en <= CTRL_PORT_EN_RST;
      pace_en <= CTRL_PACE_EN_RST;
    end
    else if (wr_ctrl)
    begin
      port_en <= reg_req.wdata[CTRL_PORT_EN];
      pace_en <= reg_req.wdata[CTRL_PACE_EN];
    end
  end

  // ----------------------------------------------------------------
  // Byte hold and display pins
  // ----------------------------------------------------------------
  // Disabling the port forces the strobe low so no write can hang
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cur <= '0;
    else if (take)
      cur <= in_byte;
    else if (!port_en)
      cur.strobe <= 1'b0;
  end

  // R1 nibble to upper lines
  // R3 select from bit six
  // R4 strobe from bit seven
  // R2 spares kept off the display
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      display_upper_data_lines <= '0;
      register_select_bit      <= 1'b0;
      display_enable_strobe    <= 1'b0;
      spare_output_one         <= 1'b0;
      spare_output_two         <= 1'b0;
    end
    else
    begin
      display_upper_data_lines <= take ? in_byte.nibble : cur.nibble;
      register_select_bit      <= take ? in_byte.rs : cur.rs;
      display_enable_strobe    <= take ? in_byte.strobe
                                       : (cur.strobe & port_en);
      spare_output_one         <= take ? in_byte.spare_one : cur.spare_one;
      spare_output_two         <= take ? in_byte.spare_two : cur.spare_two;
    end
  end

  // R8 lower lines tied low
  // R7 four bit bus only
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      display_lower_data_lines <= '0;
    else
      display_lower_data_lines <= '0;
  end

  // ----------------------------------------------------------------
  // Nibble pairing and pacing monitor
  // ----------------------------------------------------------------
  // A write completes on the falling strobe; lone init nibbles can
  // leave the pairing out of step, so software may clear the phase
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase      <= PHASE_UPPER;
      upper_held <= '0;
      need_long  <= 1'b0;
    end
    else if (phase_clr)
      phase <= PHASE_UPPER;
    else if (strobe_fall && phase == PHASE_UPPER)
    begin
      phase      <= PHASE_LOWER;
      upper_held <= cur.nibble;
      need_long  <= 1'b0;
    end
    else if (strobe_fall)
    begin
      phase     <= PHASE_UPPER;
      need_long <= long_cmd;
    end
  end

  // Time since last completed write, saturating at the long wait
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      timer <= T_LONG;
    else if (strobe_fall)
      timer <= '0;
    else if (timer < T_LONG)
      timer <= timer + TIMER_W'(1);
  end

  // Sticky errors, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seq_err  <= 1'b0;
      pace_err <= 1'b0;
    end
    else
    begin
      seq_err  <= seq_bad |
                  (seq_err & ~(wr_status & reg_req.wdata[STAT_SEQ_ERR]));
      pace_err <= pace_bad |
                  (pace_err & ~(wr_status & reg_req.wdata[STAT_PACE_ERR]));
    end
  end

  // Writes completed while the port is enabled; last byte received whether or not it is
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      write_count <= '0;
      last_byte   <= '0;
    end
    else
    begin
      if (strobe_fall)
        write_count <= write_count + COUNT_W'(1);
      if (byte_valid)
        last_byte <= in_byte;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  // Unmapped offsets read as zero
  assign rd_mux =
    (reg_req.addr == OFS_CTRL)   ? DATA_W'({pace_en, port_en}) :
    (reg_req.addr == OFS_STATUS) ? DATA_W'({phase, pace_err, seq_err}) :
    (reg_req.addr == OFS_LAST)   ? DATA_W'(last_byte) :
    (reg_req.addr == OFS_COUNT)  ? DATA_W'(write_count) : '0;

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_req.rd ? rd_mux : '0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_nibble_to_upper: // R1
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      take |=> display_upper_data_lines == $past(in_byte.nibble))
    else $error("Upper data lines do not follow the nibble");

  a_spare_no_effect: // R2
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      (take && in_byte.nibble == cur.nibble && in_byte.rs == cur.rs &&
       in_byte.strobe == cur.strobe && display_enable_strobe == cur.strobe)
      |=> $stable(display_upper_data_lines) &&
          $stable(register_select_bit) && $stable(display_enable_strobe))
    else $error("Spare bits disturbed the display pins");

  a_select_from_bit: // R3
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      take |=> register_select_bit == $past(link_byte[6]))
    else $error("Register select does not follow bit six");

  a_strobe_from_bit: // R4
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      take |=> display_enable_strobe == $past(link_byte[7]))
    else $error("Strobe does not follow bit seven");

  a_strobe_off_disabled: // R4
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!port_en)[*2] |-> !display_enable_strobe)
    else $error("Strobe high while port disabled");

  a_lower_lines_low: // R8
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      ##1 display_lower_data_lines == '0)
    else $error("Lower data lines driven");

  a_pins_hold_idle: // R7
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!byte_valid && port_en)[*2] |-> $stable(display_upper_data_lines)
        && $stable(register_select_bit))
    else $error("Display pins moved with no byte");

  a_count_on_write: // R5
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      strobe_fall |=> write_count == $past(write_count) + COUNT_W'(1)
        && timer == '0)
    else $error("Completed write not counted");

  a_pace_flag_set: // R10
    assert property (@(posedge ref_clk) disable iff (!reset_n)
      pace_bad |=> pace_err)
    else $error("Early strobe not flagged");

endmodule // spilcd_top

// ==== verif/spi_lcd_nibble_writer_tb_top.sv ====
// Self-checking bench for the serial character display port
`timescale 1ns/10ps
module spi_lcd_nibble_writer_tb_top
  import spilcd_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  // Short pacing counts keep the run brief
  localparam int unsigned SHORT_WAIT = 20;
  localparam int unsigned LONG_WAIT  = 60;
  logic              ref_clk;
  logic              reset_n;
  spilcd_req_s       reg_req;
  logic [DATA_W-1:0] reg_rdata;
  logic              spi_sclk;
  logic              spi_cs_n;
  logic              spi_mosi;
  logic [3:0]        up_lines;
  logic [3:0]        low_lines;
  logic              sel_bit;
  logic              strobe;
  logic              spare_one;
  logic              spare_two;
  logic [7:0]        nib_count;
  logic [7:0]        last_byte;
  logic              last_sel;
  logic              lower_err;
  int                fail_count;
  int                compares;

  spilcd_top #(.WAIT_SHORT(SHORT_WAIT), .WAIT_LONG(LONG_WAIT)) uut
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .display_upper_data_lines(up_lines),
    .display_lower_data_lines(low_lines), .register_select_bit(sel_bit),
    .display_enable_strobe(strobe), .spare_output_one(spare_one),
    .spare_output_two(spare_two)
  );

  spilcd_disp_model disp
  (
    .upper_lines(up_lines), .lower_lines(low_lines), .sel_line(sel_bit),
    .strobe_line(strobe), .nib_count(nib_count), .last_byte(last_byte),
    .last_sel(last_sel), .lower_err(lower_err)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic [31:0] m);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    reg_req <= '0;
    #1 chk(reg_rdata & m, e);
  endtask

  task automatic pins_chk(input logic [7:0] s);
    chk({20'h0, low_lines, up_lines, sel_bit, strobe, spare_two, spare_one},
        {20'h0, 4'h0, s[3:0], s[6], s[7], s[5], s[4]});
  endtask

  // Link clock runs only inside a frame; data idle shows the inverse
  task automatic spi_byte(input logic [7:0] b, input logic [7:0] shown);
    @(posedge ref_clk);
    spi_cs_n <= 1'b0;
    spi_mosi <= b[7];
    for (int i = 7; i >= 0; i--)
    begin
      #6 spi_sclk <= 1'b1;
      #6 spi_sclk <= 1'b0;
      spi_mosi <= (i > 0) ? b[i-1] : ~b[0];
    end
    @(posedge ref_clk);
    spi_cs_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 pins_chk(shown);
  endtask

  // Frame cut after four bits; the receiver must drop it
  task automatic spi_cut(input logic [3:0] b);
    @(posedge ref_clk);
    spi_cs_n <= 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      spi_mosi <= b[i];
      #6 spi_sclk <= 1'b1;
      #6 spi_sclk <= 1'b0;
    end
    @(posedge ref_clk);
    spi_cs_n <= 1'b1;
  endtask

  task automatic disp_write(input logic [3:0] n, input logic s);
    spi_byte({1'b0, s, 2'b00, n}, {1'b0, s, 2'b00, n});
    spi_byte({1'b1, s, 2'b00, n}, {1'b1, s, 2'b00, n});
    spi_byte({1'b0, s, 2'b00, n}, {1'b0, s, 2'b00, n});
  endtask

  task automatic send_byte(input logic [7:0] b, input logic s);
    disp_write(b[7:4], s);
    disp_write(b[3:0], s);
  endtask

  task automatic model_chk(input logic [7:0] b, input logic s,
                           input logic [7:0] n);
    chk({24'h0, last_byte}, {24'h0, b});
    chk({31'h0, last_sel}, {31'h0, s});
    chk({24'h0, nib_count}, {24'h0, n});
    chk({31'h0, lower_err}, 32'h0);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic check_reset_values();
    pins_chk(8'h00);
    reg_chk(OFS_CTRL, 32'h3, 32'h7);
    reg_chk(OFS_STATUS, 32'h0, 32'h7);
    reg_chk(OFS_COUNT, 32'h0, 32'hffff);
    reg_chk(8'h10, 32'h0, 32'hffffffff);
  endtask

  task automatic check_char_byte();
    send_byte(8'h41, 1'b1);
    model_chk(8'h41, 1'b1, 8'h02);
    reg_chk(OFS_COUNT, 32'h2, 32'hffff);
    reg_chk(OFS_LAST, 32'h41, 32'hff);
  endtask

  task automatic check_spare_bits();
    spi_byte(8'h30, 8'h30);
    chk({24'h0, nib_count}, 32'h2);
    spi_byte(8'h00, 8'h00);
    chk({24'h0, nib_count}, 32'h2);
  endtask

  // A write soon after a clear command is flagged early pacing;
  // one after the full long wait following home is not
  task automatic check_pacing();
    send_byte(CMD_CLEAR, 1'b0);
    model_chk(CMD_CLEAR, 1'b0, 8'h04);
    reg_chk(OFS_STATUS, 32'h0, 32'h2);
    send_byte(8'h80, 1'b0);
    reg_chk(OFS_STATUS, 32'h2, 32'h2);
    reg_wr(OFS_STATUS, 32'h2);
    reg_chk(OFS_STATUS, 32'h0, 32'h2);
    model_chk(8'h80, 1'b0, 8'h06);
    reg_chk(OFS_COUNT, 32'h6, 32'hffff);
    send_byte(CMD_HOME, 1'b0);
    repeat (LONG_WAIT) @(posedge ref_clk);
    send_byte(8'h80, 1'b0);
    reg_chk(OFS_STATUS, 32'h0, 32'h2);
    model_chk(8'h80, 1'b0, 8'h0a);
  endtask

  task automatic check_port_off();
    reg_wr(OFS_CTRL, 32'h2);
    spi_byte(8'hca, 8'h00);
    reg_chk(OFS_LAST, 32'hca, 32'hff);
    reg_wr(OFS_CTRL, 32'h3);
    reg_chk(OFS_CTRL, 32'h3, 32'h7);
    spi_cut(4'hf);
    reg_chk(OFS_LAST, 32'hca, 32'hff);
  endtask

  // Data change while the strobe is high is a sequence fault
  task automatic check_seq_error();
    spi_byte(8'h05, 8'h05);
    reg_wr(OFS_STATUS, 32'h1);
    spi_byte(8'h85, 8'h85);
    reg_chk(OFS_STATUS, 32'h0, 32'h1);
    spi_byte(8'h86, 8'h86);
    reg_chk(OFS_STATUS, 32'h1, 32'h1);
    spi_byte(8'h06, 8'h06);
    chk({24'h0, nib_count}, 32'hb);
    reg_chk(OFS_COUNT, 32'hb, 32'hffff);
    reg_chk(OFS_STATUS, 32'h4, 32'h4);
    reg_wr(OFS_CTRL, 32'h7);
    reg_chk(OFS_STATUS, 32'h0, 32'h4);
    reg_chk(OFS_CTRL, 32'h3, 32'h7);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and run limit
  // ----------------------------------------------------------------
  initial
  begin
    reset_n    = 1'b0;
    reg_req    = '0;
    spi_sclk   = 1'b0;
    spi_cs_n   = 1'b1;
    spi_mosi   = 1'b0;
    fail_count = 0;
    compares   = 0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    check_reset_values();
    check_char_byte();
    check_spare_bits();
    check_pacing();
    check_port_off();
    check_seq_error();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    test_done();
  end
endmodule // spi_lcd_nibble_writer_tb_top

// ==== verif/spilcd_disp_model.sv ====
// Behavioural character display sink in four bit write-only mode
`timescale 1ns/10ps
module spilcd_disp_model
(
  // Display pins
  input  wire logic [3:0] upper_lines,
  input  wire logic [3:0] lower_lines,
  input  wire logic       sel_line,
  input  wire logic       strobe_line,
  // Observed results
  output logic [7:0]      nib_count,
  output logic [7:0]      last_byte,
  output logic            last_sel,
  output logic            lower_err
);
  logic [3:0] high_part;
  logic       strobe_prev;

  initial
  begin
    nib_count   = 8'h00;
    last_byte   = 8'h00;
    last_sel    = 1'b0;
    lower_err   = 1'b0;
    high_part   = 4'h0;
    strobe_prev = 1'b0;
  end

  // Latch only on a clean high to low edge; reset edges from X are ignored
  // nibble latched at strobe fall, upper half first
  always @(strobe_line)
  begin
    if (strobe_line === 1'b0 && strobe_prev === 1'b1)
    begin
      // unused lower lines must read low
      if (lower_lines !== 4'h0)
        lower_err = 1'b1;
      if (nib_count[0] == 1'b0)
        high_part = upper_lines;
      else
      begin
        last_byte = {high_part, upper_lines};
        last_sel  = sel_line;
      end
      nib_count = nib_count + 8'h01;
    end
    strobe_prev = strobe_line;
  end
endmodule // spilcd_disp_model
